// ==== src/sram_host_ctrl.v ====
`timescale 1ns/1ps
`include "sram_host_map.vh"
// Functional notes
// - Raise all qualifiers before write; write ends when first one drops.
// - Host holds write data stable around the edge that ends the write.
// - Host keeps write strobe high during every read.
// - Host presents address no later than active-low select falling.
// - Strobe-timed write with output enable low lasts setup plus float delay.
module sram_host_ctrl #(
    parameter AW = `ADDR_W,
    parameter DW = `DATA_W
) (
    input wire clk,
    input wire reset,
    input wire req_valid,
    output wire req_ready,
    input wire req_write,
    input wire [AW-1:0] req_addr,
    input wire [DW-1:0] req_wdata,
    input wire [1:0] req_lanes,
    output reg rsp_valid,
    output reg [DW-1:0] rsp_rdata,
    output reg [AW-1:0] mem_addr,
    output reg select_low_active_n,
    output reg select_high_active,
    output reg write_strobe_n,
    output reg output_enable_n,
    output reg lower_byte_lane_n,
    output reg upper_byte_lane_n,
    output reg [DW-1:0] data_out,
    output reg [DW-1:0] data_oe,
    input wire [DW-1:0] data_in
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_READ = 3'h1;
    localparam [2:0] S_WRITE = 3'h2;
    localparam [2:0] S_HOLD = 3'h3;
    localparam [2:0] S_FLOAT = 3'h4;

    localparam CW = 4;
    // Timer loads: a load of n holds the state for n + 1 cycles
    localparam integer READ_CNT_I = `READ_CYC + 2;
    localparam integer WRITE_CNT_I = `WRITE_PULSE_CYC;
    localparam integer FLOAT_CNT_I = `FLOAT_CYC;
    localparam integer RECOVER_CNT_I = `WRITE_RECOVERY_CYC;
    localparam [CW-1:0] READ_CNT = READ_CNT_I[CW-1:0];
    localparam [CW-1:0] WRITE_CNT = WRITE_CNT_I[CW-1:0];
    localparam [CW-1:0] FLOAT_CNT = FLOAT_CNT_I[CW-1:0];
    localparam [CW-1:0] RECOVER_CNT = RECOVER_CNT_I[CW-1:0];

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [DW-1:0] data_in_s1_q;
    reg [DW-1:0] data_in_s2_q;
    reg [1:0] lanes_q;
    reg t_load;
    reg [CW-1:0] t_count;
    wire t_done;
    wire [DW-1:0] lane_mask;
    wire [DW-1:0] req_lane_mask;
    genvar gi;

    sram_wait_timer #(.CW(CW)) u_timer (
        .clk(clk),
        .reset(reset),
        .load(t_load),
        .count(t_count),
        .done(t_done)
    );

    // Read data pins cross in through two flops
    always @(posedge clk) begin
        data_in_s1_q <= data_in;
        data_in_s2_q <= data_in_s1_q;
    end

    // Per-bit lane masks for the held and the incoming request
    generate
        for (gi = 0; gi < DW; gi = gi + 1) begin : g_lane
            if (gi <= `LANE_LO_MSB) begin : g_lo
                assign lane_mask[gi] = lanes_q[0];
                assign req_lane_mask[gi] = req_lanes[0];
            end else begin : g_hi
                assign lane_mask[gi] = lanes_q[1];
                assign req_lane_mask[gi] = req_lanes[1];
            end
        end
    endgenerate

    // Requests are accepted only in idle
    assign req_ready = (state_q == S_IDLE);

    // Next state and timer loads
    always @* begin
        state_d = state_q;
        t_load = 1'b0;
        t_count = {CW{1'b0}};
        case (state_q)
            S_IDLE: begin
                if (req_valid && req_lanes != 2'b00) begin
                    t_load = 1'b1;
                    if (req_write) begin
                        t_count = WRITE_CNT;
                        state_d = S_WRITE;
                    end else begin
                        t_count = READ_CNT;
                        state_d = S_READ;
                    end
                end
            end
            S_READ: begin
                if (t_done) begin
                    t_load = 1'b1;
                    t_count = FLOAT_CNT;
                    state_d = S_FLOAT;
                end
            end
            S_WRITE: begin
                if (t_done) begin
                    state_d = S_HOLD;
                end
            end
            S_HOLD: begin
                t_load = 1'b1;
                t_count = RECOVER_CNT;
                state_d = S_FLOAT;
            end
            S_FLOAT: begin
                if (t_done) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // State register
    always @(posedge clk) begin
        if (reset) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Pin drive registers
    always @(posedge clk) begin
        if (reset) begin
            lanes_q <= 2'b00;
            mem_addr <= {AW{1'b0}};
            select_low_active_n <= 1'b1;
            select_high_active <= 1'b0;
            write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            lower_byte_lane_n <= 1'b1;
            upper_byte_lane_n <= 1'b1;
            data_out <= {DW{1'b0}};
            data_oe <= {DW{1'b0}};
        end else begin
            if (state_q == S_IDLE && state_d != S_IDLE) begin
                // Address and lanes settle with selects in one edge
                mem_addr <= req_addr;
                lanes_q <= req_lanes;
                select_low_active_n <= 1'b0;
                select_high_active <= 1'b1;
                lower_byte_lane_n <= ~req_lanes[0];
                upper_byte_lane_n <= ~req_lanes[1];
                if (req_write) begin
                    write_strobe_n <= 1'b0;
                    output_enable_n <= 1'b1;
                    data_out <= req_wdata;
                    data_oe <= req_lane_mask;
                end else begin
                    write_strobe_n <= 1'b1;
                    output_enable_n <= 1'b0;
                    data_oe <= {DW{1'b0}};
                end
            end

            if (state_q == S_WRITE && t_done) begin
                // Strobe alone ends the write; data stays one more cycle
                write_strobe_n <= 1'b1;
            end

            if (state_q == S_HOLD) begin
                // Data released only after the strobe has risen
                data_oe <= {DW{1'b0}};
                select_low_active_n <= 1'b1;
                select_high_active <= 1'b0;
                lower_byte_lane_n <= 1'b1;
                upper_byte_lane_n <= 1'b1;
            end

            if (state_q == S_READ && t_done) begin
                // Read done: close the cycle
                output_enable_n <= 1'b1;
                select_low_active_n <= 1'b1;
                select_high_active <= 1'b0;
                lower_byte_lane_n <= 1'b1;
                upper_byte_lane_n <= 1'b1;
            end
        end
    end

    // Read response register; unselected lanes read as zero
    always @(posedge clk) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= {DW{1'b0}};
        end else begin
            rsp_valid <= 1'b0;
            if (state_q == S_READ && t_done) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_in_s2_q & lane_mask;
            end
        end
    end
endmodule // sram_host_ctrl

// ==== src/sram_host_map.vh ====
`ifndef SRAM_HOST_MAP_VH
`define SRAM_HOST_MAP_VH

// Array shape
`define ADDR_W 18
`define DATA_W 16
`define LANE_LO_MSB 7
`define LANE_HI_LSB 8

// Timing figures in ns
`define CLK_PERIOD_NS 8
`define READ_CYCLE_NS 45
`define ADDR_TO_WRITE_END_NS 35
`define WRITE_PULSE_NS 35
`define DATA_SETUP_TIME_NS 25
`define STROBE_LOW_TO_FLOAT_DELAY_NS 18
`define OUTPUT_FLOAT_NS 18
`define WRITE_CYCLE_NS 45

// Cycle counts: least times round up
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC `CEIL_CYC(`READ_CYCLE_NS)
`define WRITE_PULSE_CYC `CEIL_CYC(`DATA_SETUP_TIME_NS + `STROBE_LOW_TO_FLOAT_DELAY_NS)
`define FLOAT_CYC `CEIL_CYC(`OUTPUT_FLOAT_NS)
`define WRITE_RECOVERY_CYC `CEIL_CYC(`WRITE_CYCLE_NS - `WRITE_PULSE_NS)

`endif

// ==== src/sram_wait_timer.v ====
`timescale 1ns/1ps
// Loadable down counter; done is high while the count is zero
module sram_wait_timer #(
    parameter CW = 4
) (
    input wire clk,
    input wire reset,
    input wire load,
    input wire [CW-1:0] count,
    output wire done
);
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;

    always @* begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = count;
        end else if (cnt_q != {CW{1'b0}}) begin
            cnt_d = cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            cnt_q <= {CW{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == {CW{1'b0}});
endmodule // sram_wait_timer

// ==== tb/async_sram_byte_lane_access_tb.sv ====
`timescale 1ns/1ps
module async_sram_byte_lane_access_tb;
    reg clk = 0, reset = 1, req_valid = 0, req_write = 0;
    reg [17:0] req_addr = 0;
    reg [15:0] req_wdata = 0;
    reg [1:0] req_lanes = 0;
    wire req_ready, rsp_valid, cs_n, cs, we_n, oe_n, lb_n, ub_n;
    wire [15:0] rsp_rdata, data_out, data_oe, q;
    wire [17:0] mem_addr;
    wire [15:0] data_in = (data_out & data_oe) | (q & ~data_oe);
    integer n_mismatch = 0, n_compared = 0;
    always #4 clk = ~clk;
    sram_host_ctrl i_dut (.clk(clk), .reset(reset), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_lanes(req_lanes), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .select_low_active_n(cs_n),
        .select_high_active(cs), .write_strobe_n(we_n), .output_enable_n(oe_n),
        .lower_byte_lane_n(lb_n), .upper_byte_lane_n(ub_n), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in));
    sram_model i_mem (.clk(clk), .a(mem_addr), .select_low_active_n(cs_n),
        .select_high_active(cs), .write_strobe_n(we_n), .output_enable_n(oe_n),
        .lower_byte_lane_n(lb_n), .upper_byte_lane_n(ub_n), .d(data_in), .q(q));
    task chk(input [15:0] got, input [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task req(input w, input [17:0] a, input [15:0] d, input [1:0] l);
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_lanes = l;
        @(negedge clk);
        req_valid = 0;
    endtask
    task rd(input [17:0] a, input [1:0] l, input [15:0] exp);
        integer k;
        req(0, a, 16'h0000, l);
        k = 0;
        while (rsp_valid !== 1'b1 && k < 20) begin
            @(negedge clk);
            k = k + 1;
        end
        chk(k[15:0], 16'h0009);
        chk(rsp_rdata, exp);
    endtask
    task s_idle;
        chk({cs_n, cs, we_n, oe_n, lb_n, ub_n}, 16'h002F);
        chk(data_oe, 16'h0000);
    endtask
    task s_word;
        req(1, 18'h3_FFFF, 16'hA5C3, 2'b11);
        req(1, 18'h0_0000, 16'h1234, 2'b11);
        rd(18'h3_FFFF, 2'b11, 16'hA5C3);
        rd(18'h0_0000, 2'b11, 16'h1234);
    endtask
    task s_lanes;
        req(1, 18'h3_FFFF, 16'h7E81, 2'b01);
        rd(18'h3_FFFF, 2'b11, 16'hA581);
        rd(18'h3_FFFF, 2'b10, 16'hA500);
        req(1, 18'h3_FFFF, 16'h0F00, 2'b10);
        rd(18'h3_FFFF, 2'b01, 16'h0081);
        rd(18'h3_FFFF, 2'b11, 16'h0F81);
    endtask
    task s_drop;
        req(1, 18'h0_0000, 16'hFFFF, 2'b00);
        chk({15'h0000, req_ready}, 16'h0001);
        rd(18'h0_0000, 2'b11, 16'h1234);
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        end_sim;
    end
    initial begin
        repeat (10) @(negedge clk);
        reset = 0;
        s_idle;
        s_word;
        s_lanes;
        s_drop;
        s_idle;
        end_sim;
    end
endmodule // async_sram_byte_lane_access_tb

// ==== tb/sram_host_ctrl_assertions.sv ====
`timescale 1ns/1ps
module sram_host_ctrl_assertions #(
    parameter AW = 18,
    parameter DW = 16
) (
    input wire clk,
    input wire reset,
    input wire [AW-1:0] mem_addr,
    input wire select_low_active_n,
    input wire select_high_active,
    input wire write_strobe_n,
    input wire output_enable_n,
    input wire lower_byte_lane_n,
    input wire upper_byte_lane_n,
    input wire [DW-1:0] data_out,
    input wire [DW-1:0] data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire sel = !select_low_active_n && select_high_active;
    property p_qual;
        !write_strobe_n |-> sel && !(lower_byte_lane_n && upper_byte_lane_n) && data_oe != 0;
    endproperty
    a_qual: assert property (p_qual) else $error("strobe low without qualifiers");
    property p_hold;
        $rose(write_strobe_n) |-> data_oe != 0 && $stable(data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("data not held at write end");
    property p_rd;
        !output_enable_n |-> write_strobe_n && data_oe == 0;
    endproperty
    a_rd: assert property (p_rd) else $error("strobe or drive during read");
    property p_addr;
        sel && $past(sel) |-> $stable(mem_addr);
    endproperty
    a_addr: assert property (p_addr) else $error("address moved while selected");
    property p_pulse;
        $fell(write_strobe_n) |-> !write_strobe_n [*7] ##1 write_strobe_n;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe pulse not seven cycles");
endmodule // sram_host_ctrl_assertions
bind sram_host_ctrl sram_host_ctrl_assertions #(.AW(AW), .DW(DW)) i_chk (.clk(clk),
    .reset(reset), .mem_addr(mem_addr), .select_low_active_n(select_low_active_n),
    .select_high_active(select_high_active), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .lower_byte_lane_n(lower_byte_lane_n),
    .upper_byte_lane_n(upper_byte_lane_n), .data_out(data_out), .data_oe(data_oe));

// ==== tb/sram_model.sv ====
`timescale 1ns/1ps
module sram_model (
    input wire clk,
    input wire [17:0] a,
    input wire select_low_active_n,
    input wire select_high_active,
    input wire write_strobe_n,
    input wire output_enable_n,
    input wire lower_byte_lane_n,
    input wire upper_byte_lane_n,
    input wire [15:0] d,
    output wire [15:0] q
);
    reg [15:0] mem [0:262143];
    integer i;
    wire on = !select_low_active_n && select_high_active;
    wire [15:0] ln = {{8{!upper_byte_lane_n}}, {8{!lower_byte_lane_n}}};
    wire [15:0] rd = mem[a];
    wire [15:0] en = (on && !output_enable_n && write_strobe_n) ? ln : 16'h0000;
    // Floating bits show the inverse of the stored value
    assign q = (rd & en) | (~rd & ~en);
    initial begin
        for (i = 0; i < 262144; i = i + 1) mem[i] = 16'h0000;
    end
    always @(posedge clk) begin
        if (on && !write_strobe_n) mem[a] <= (mem[a] & ~ln) | (d & ln);
    end
endmodule // sram_model
